// >>> logic/fp_exc_pkg.sv
/*
 * Constants for the floating-point arithmetic exception unit: register
 * byte addresses, field positions, class order, vectors and frame codes.
 * Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
 */
package fp_exc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  STAT_ADDR   = 8'h04;
    localparam logic [7:0]  RPT_ADDR    = 8'h08;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] STAT_RST    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned EN_LSB       = 8;
    localparam int unsigned EN_MSB       = 15;
    localparam int unsigned EXC_LSB      = 8;
    localparam int unsigned EXC_MSB      = 15;
    localparam int unsigned CC_LSB       = 24;
    localparam int unsigned CC_MSB       = 27;
    localparam int unsigned CC_NAN       = 0;
    localparam int unsigned RPT_PEND_BIT = 0;
    localparam int unsigned RPT_QUIET    = 1;
    localparam int unsigned RPT_CLS_LSB  = 8;
    localparam int unsigned RPT_VEC_LSB  = 16;

    // ------------------------------------------------------------------
    // Exception classes, index 7 is the highest priority
    // ------------------------------------------------------------------
    localparam logic [2:0] CLS_UNORD   = 3'h7;
    localparam logic [7:0] HW_EXC_MASK = 8'hFE;
    localparam logic [7:0] NM_MASK     = 8'h78;
    localparam logic [7:0] VEC_UNORD   = 8'h30;
    localparam logic [3:0] FRAME_PRE   = 4'h0;
    localparam logic [3:0] FRAME_POST  = 4'h3;

    // ------------------------------------------------------------------
    // Conditional predicate
    // ------------------------------------------------------------------
    localparam int unsigned PRED_SEL_BIT = 7;
    localparam int unsigned PRED_W       = 6;
    localparam int unsigned PRED_NONAWARE = 4;

endpackage

// >>> logic/fp_arith_exception_unit.sv
/*
 * Floating-point arithmetic exception unit: ranks eight exception classes,
 * qualifies all but nonmaskable ones by the enable byte, holds a pending exception for the
 * next floating-point instruction, and checks conditional instructions for
 * the unordered condition. Registers sit on an AXI4-Lite slave.
 * Assumes the sequencer drives its strobes on clk and restarts an
 * instruction whenever a pre-instruction exception is taken for it.
 */
`timescale 1ns/10ps

module fp_arith_exception_unit
(
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [fp_exc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [fp_exc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      op_done,
    input  wire logic [7:0]                op_exc,
    input  wire logic                      op_nonmask,
    input  wire logic [3:0]                op_cc,
    input  wire logic                      instr_arrive,
    input  wire logic                      cond_req,
    input  wire logic [15:0]               cond_opword,
    input  wire logic [15:0]               cond_ext,
    input  wire logic                      fpu_idle,
    input  wire logic                      fp_state_save_instr_done,
    output logic                           exc_take,
    output logic [7:0]                     exc_vector,
    output logic                           exc_pre,
    output logic [3:0]                     exc_frame,
    output logic                           cond_done,
    output logic [5:0]                     cond_pred
);
    import fp_exc_pkg::*;

    typedef enum logic [0:0] {CS_IDLE, CS_WAIT} cond_state_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] top_class(input logic [7:0] v);
        top_class = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                top_class = 3'(i);
            end
        end
    endfunction

    function automatic logic [7:0] vec_of(input logic [2:0] cls);
        vec_of = VEC_UNORD + {5'h00, CLS_UNORD - cls};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        aw_have_r, aw_have_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic        w_have_r, w_have_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        awready_r, awready_nxt;
    logic        wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [7:0]  en_r, en_nxt;
    logic [7:0]  exc_r, exc_nxt;
    logic [3:0]  cc_r, cc_nxt;
    logic        pend_r, pend_nxt;
    logic [2:0]  pend_cls_r, pend_cls_nxt;
    logic        quiet_r, quiet_nxt;
    cond_state_t cs_r, cs_nxt;
    logic [5:0]  pred_r, pred_nxt;
    logic        take_r, take_nxt;
    logic [7:0]  vec_r, vec_nxt;
    logic        pre_r, pre_nxt;
    logic [3:0]  frame_r, frame_nxt;
    logic        done_r, done_nxt;
    logic [5:0]  cpred_r, cpred_nxt;

    logic        wr_fire;
    logic        ctl_wr;
    logic        st_wr;
    logic [31:0] ctl_word;
    logic [31:0] st_word;
    logic [31:0] rpt_word;
    logic [31:0] ctl_w;
    logic [31:0] st_w;
    logic [7:0]  masked;
    logic [7:0]  nonmask;
    logic        unord_hit;

    assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    assign ctl_wr  = wr_fire && (aw_addr_r == CTRL_ADDR);
    assign st_wr   = wr_fire && (aw_addr_r == STAT_ADDR);

    // The enable byte and the status byte share one bit order.
    assign ctl_word = {16'h0000, en_r, 8'h00};
    assign st_word  = {4'h0, cc_r, 8'h00, exc_r, 8'h00};
    assign rpt_word = {8'h00, vec_of(pend_cls_r), 5'h00, pend_cls_r,
                       6'h00, quiet_r, pend_r};
    assign ctl_w    = merge(ctl_word, w_data_r, w_strb_r);
    assign st_w     = merge(st_word, w_data_r, w_strb_r);

    // Inexact-decimal is never raised by hardware.
    assign masked  = op_exc & HW_EXC_MASK & en_r;
    // Unordered is outside the nonmaskable set.
    assign nonmask = op_nonmask ? (op_exc & NM_MASK) : 8'h00;

    assign unord_hit = pred_r[PRED_NONAWARE] && cc_r[CC_NAN];

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    always_comb
    begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt  = w_have_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_awvalid && awready_r)
        begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = (ctl_wr || st_wr) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_nxt = ~aw_have_nxt;
        wready_nxt  = ~w_have_nxt;
        if (s_axi_arvalid && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_ADDR: rdata_nxt = ctl_word;
                STAT_ADDR: rdata_nxt = st_word;
                RPT_ADDR:  rdata_nxt = rpt_word;
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r  <= w_have_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Exception ranking, pending state and conditional sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        en_nxt       = ctl_wr ? ctl_w[EN_MSB:EN_LSB] : en_r;
        // Software writes only store; they never arm a pending trap.
        exc_nxt      = st_wr ? st_w[EXC_MSB:EXC_LSB] : exc_r;
        cc_nxt       = st_wr ? st_w[CC_MSB:CC_LSB] : cc_r;
        pend_nxt     = pend_r;
        pend_cls_nxt = pend_cls_r;
        quiet_nxt    = quiet_r;
        cs_nxt       = cs_r;
        pred_nxt     = pred_r;
        take_nxt     = 1'b0;
        vec_nxt      = vec_r;
        pre_nxt      = pre_r;
        frame_nxt    = frame_r;
        done_nxt     = 1'b0;
        cpred_nxt    = cpred_r;
        if (fp_state_save_instr_done)
        begin
            pend_nxt  = 1'b0;
            quiet_nxt = 1'b1;
        end
        if (instr_arrive && pend_r)
        begin
            take_nxt  = 1'b1;
            vec_nxt   = vec_of(pend_cls_r);
            pre_nxt   = 1'b1;
            frame_nxt = FRAME_PRE;
            pend_nxt  = 1'b0;
        end
        case (cs_r)
            CS_IDLE:
            begin
                if (cond_req)
                begin
                    // Predicate lives in the opword or the next word.
                    pred_nxt = cond_opword[PRED_SEL_BIT] ?
                               cond_opword[PRED_W-1:0] : cond_ext[PRED_W-1:0];
                    cs_nxt   = CS_WAIT;
                end
            end
            CS_WAIT:
            begin
                if (pend_r)
                begin
                    // Earlier exception first; the sequencer restarts us.
                    take_nxt  = 1'b1;
                    vec_nxt   = vec_of(pend_cls_r);
                    pre_nxt   = 1'b1;
                    frame_nxt = FRAME_PRE;
                    pend_nxt  = 1'b0;
                    cs_nxt    = CS_IDLE;
                end
                else if (fpu_idle)
                begin
                    cs_nxt    = CS_IDLE;
                    // A save landing in this same cycle still quiets the next check.
                    quiet_nxt = fp_state_save_instr_done;
                    if (unord_hit)
                    begin
                        exc_nxt[CLS_UNORD] = 1'b1;
                    end
                    if (unord_hit && en_r[CLS_UNORD] && !quiet_r)
                    begin
                        // Trap before evaluating; a rerun traps again.
                        take_nxt  = 1'b1;
                        vec_nxt   = VEC_UNORD;
                        pre_nxt   = 1'b1;
                        frame_nxt = FRAME_PRE;
                    end
                    else
                    begin
                        // Nonaware tests fall back to the aware form.
                        done_nxt  = 1'b1;
                        cpred_nxt = pred_r;
                        cpred_nxt[PRED_NONAWARE] = 1'b0;
                    end
                end
            end
            default:
            begin
                cs_nxt = CS_IDLE;
            end
        endcase
        if (op_done)
        begin
            // All flagged classes but inexact-decimal are recorded at once.
            exc_nxt = exc_nxt | (op_exc & HW_EXC_MASK);
            cc_nxt  = op_cc;
            if (|nonmask)
            begin
                // Taken at once, ranked against enabled ones.
                take_nxt  = 1'b1;
                vec_nxt   = vec_of(top_class(nonmask | masked));
                pre_nxt   = 1'b0;
                frame_nxt = FRAME_POST;
                pend_nxt  = 1'b0;
            end
            else if (|masked)
            begin
                // Only the top class survives; lower ones are dropped.
                pend_nxt     = 1'b1;
                pend_cls_nxt = top_class(masked);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            en_r       <= CTRL_RST[EN_MSB:EN_LSB];
            exc_r      <= STAT_RST[EXC_MSB:EXC_LSB];
            cc_r       <= STAT_RST[CC_MSB:CC_LSB];
            pend_r     <= 1'b0;
            pend_cls_r <= 3'h0;
            quiet_r    <= 1'b0;
            cs_r       <= CS_IDLE;
            pred_r     <= 6'h00;
            take_r     <= 1'b0;
            vec_r      <= 8'h00;
            pre_r      <= 1'b0;
            frame_r    <= FRAME_PRE;
            done_r     <= 1'b0;
            cpred_r    <= 6'h00;
        end
        else
        begin
            en_r       <= en_nxt;
            exc_r      <= exc_nxt;
            cc_r       <= cc_nxt;
            pend_r     <= pend_nxt;
            pend_cls_r <= pend_cls_nxt;
            quiet_r    <= quiet_nxt;
            cs_r       <= cs_nxt;
            pred_r     <= pred_nxt;
            take_r     <= take_nxt;
            vec_r      <= vec_nxt;
            pre_r      <= pre_nxt;
            frame_r    <= frame_nxt;
            done_r     <= done_nxt;
            cpred_r    <= cpred_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign exc_take      = take_r;
    assign exc_vector    = vec_r;
    assign exc_pre       = pre_r;
    assign exc_frame     = frame_r;
    assign cond_done     = done_r;
    assign cond_pred     = cpred_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_inexdec_quiet: assert property (
        (!st_wr && !exc_r[0]) |=> !exc_r[0])
        else $error("inexact-decimal bit set by hardware");

    chk_mask_needed: assert property (
        (op_done && masked == 8'h00 && !pend_r) |=> !pend_r)
        else $error("pending without enabled status bit");

    chk_swstat_noarm: assert property (
        (st_wr && !op_done && !pend_r) |=> !pend_r)
        else $error("status write armed an exception");

    chk_swen_noarm: assert property (
        (ctl_wr && !op_done && !pend_r) |=> !pend_r)
        else $error("enable write armed an exception");

    chk_nonmask_take: assert property (
        (op_done && |nonmask) |=> (exc_take && !exc_pre && exc_frame == FRAME_POST))
        else $error("nonmaskable condition not taken");

    chk_top_only: assert property (
        (op_done && nonmask == 8'h00 && |masked)
        |=> (pend_r && pend_cls_r == top_class($past(masked))))
        else $error("pending class is not the highest");

    chk_pre_first: assert property (
        (cs_r == CS_WAIT && pend_r && !op_done)
        |=> (exc_take && exc_pre && !cond_done && cs_r == CS_IDLE))
        else $error("pending exception not taken first");

    chk_busy_hold: assert property (
        (cs_r == CS_WAIT && !fpu_idle && !pend_r) |=> (!cond_done && cs_r == CS_WAIT))
        else $error("predicate evaluated while busy");

    chk_aware_form: assert property (
        cond_done |-> !cond_pred[PRED_NONAWARE])
        else $error("nonaware predicate left unconverted");

    chk_unord_vec: assert property (
        (cs_r == CS_WAIT && !pend_r && fpu_idle && unord_hit && en_r[CLS_UNORD] && !quiet_r
         && !op_done) |=> (exc_take && exc_vector == VEC_UNORD && exc_frame == FRAME_PRE
         && exc_r[CLS_UNORD]))
        else $error("unordered trap not raised correctly");

    chk_save_quiet: assert property (
        fp_state_save_instr_done |=> (quiet_r && !pend_r))
        else $error("state save did not quiet the unit");

endmodule

// >>> verification/fp_seq_model.sv
/*
 * Sequencer model: drives the core strobes of the exception unit.
 * Assumes its tasks are called from the bench on the same clock.
 */
`timescale 1ns/10ps

module fp_seq_model
(
    input  wire logic        clk,
    output logic             op_done,
    output logic [7:0]       op_exc,
    output logic             op_nonmask,
    output logic [3:0]       op_cc,
    output logic             instr_arrive,
    output logic             cond_req,
    output logic [15:0]      cond_opword,
    output logic [15:0]      cond_ext,
    output logic             fpu_idle,
    output logic             fp_state_save_instr_done
);
    initial
    begin
        {op_done, op_exc, op_nonmask, op_cc, instr_arrive, cond_req} = '0;
        {cond_opword, cond_ext, fp_state_save_instr_done} = '0;
        fpu_idle = 1'b1;
    end

    // Idle drops while the operation is in flight, so a conditional must wait.
    task automatic op(input logic [7:0] e, input logic nm, input logic [3:0] c);
        @(posedge clk);
        fpu_idle <= 1'b0;
        @(posedge clk);
        op_done <= 1'b1;
        op_exc <= e;
        op_nonmask <= nm;
        op_cc <= c;
        @(posedge clk);
        op_done <= 1'b0;
        fpu_idle <= 1'b1;
    endtask

    task automatic arrive();
        @(posedge clk);
        instr_arrive <= 1'b1;
        @(posedge clk);
        instr_arrive <= 1'b0;
    endtask

    task automatic cond(input logic [15:0] o, input logic [15:0] x);
        @(posedge clk);
        cond_req <= 1'b1;
        cond_opword <= o;
        cond_ext <= x;
        @(posedge clk);
        cond_req <= 1'b0;
    endtask

    task automatic save();
        @(posedge clk);
        fp_state_save_instr_done <= 1'b1;
        @(posedge clk);
        fp_state_save_instr_done <= 1'b0;
    endtask
endmodule

// >>> verification/test_fp_arith_exception_unit.sv
/*
 * Self-checking bench for the exception unit, with the sequencer model.
 * Assumes the register map and vectors of fp_exc_pkg.
 */
`timescale 1ns/10ps

module test_fp_arith_exception_unit;
    import fp_exc_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        op_done, op_nonmask, instr_arrive, cond_req, fpu_idle, fp_state_save_instr_done;
    logic [7:0]  op_exc, exc_vector;
    logic [3:0]  op_cc, exc_frame;
    logic [15:0] cond_opword, cond_ext;
    logic        exc_take, exc_pre, cond_done;
    logic [5:0]  cond_pred;
    int          errors = 0, checked = 0;

    always #4 clk = ~clk;

    fp_arith_exception_unit fp_arith_exception_unit_inst (.clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .op_done, .op_exc, .op_nonmask, .op_cc, .instr_arrive, .cond_req,
        .cond_opword, .cond_ext, .fpu_idle, .fp_state_save_instr_done, .exc_take, .exc_vector, .exc_pre,
        .exc_frame, .cond_done, .cond_pred);
    fp_seq_model seq_inst (.clk, .op_done, .op_exc, .op_nonmask, .op_cc, .instr_arrive,
        .cond_req, .cond_opword, .cond_ext, .fpu_idle, .fp_state_save_instr_done);

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 50)
        begin
            errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask

    // Sampling just after the edge catches a one-cycle pulse landing on that edge.
    task automatic ev(input logic [1:0] k, input logic [7:0] v, input logic [3:0] f);
        logic [1:0] seen;
        seen = 2'd0;
        for (int n = 0; n < 12 && seen == 2'd0; n++)
        begin
            #1;
            if (exc_take === 1'b1) seen = 2'd1;
            else if (cond_done === 1'b1) seen = 2'd2;
            @(posedge clk);
        end
        chk("event", seen, k);
        if (k == 2'd1) chk("vector", exc_vector, v);
        if (k == 2'd1) chk("frame", exc_frame, f);
        if (k == 2'd1) chk("pre", exc_pre, f == FRAME_PRE);
        if (k == 2'd2) chk("pred", cond_pred, v);
    endtask

    function automatic logic [7:0] vec(input logic [7:0] m);
        vec = 8'h00;
        for (int i = 1; i < 8; i++)
            if (m[i]) vec = VEC_UNORD + 8'(7 - i);
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  en, ex, acc, m;
        void'($urandom(32'hc3981ef9));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(CTRL_ADDR, d, r);
        chk("ctrl reset", d, CTRL_RST);
        rd(STAT_ADDR, d, r);
        chk("stat reset", d, STAT_RST);
        rd(8'h0C, d, r);
        chk("unmapped", r, RESP_SLVERR);
        wr(RPT_ADDR, '1, r);
        chk("ro write", r, RESP_SLVERR);
        acc = '0;
        repeat (16)
        begin
            en = 8'($urandom);
            ex = 8'($urandom);
            acc |= ex;
            m = en & ex & HW_EXC_MASK;
            wr(CTRL_ADDR, {16'h0, en, 8'h0}, r);
            seq_inst.op(ex, 1'b0, 4'h0);
            seq_inst.arrive();
            ev({1'b0, m != 0}, vec(m), FRAME_PRE);
        end
        rd(STAT_ADDR, d, r);
        chk("status", d[15:8], acc & HW_EXC_MASK);
        wr(STAT_ADDR, 32'h0000_FF00, r);
        wr(CTRL_ADDR, 32'h0000_FF00, r);
        seq_inst.arrive();
        ev(2'd0, 8'h0, 4'h0);
        s_axi_wstrb <= 4'h1;
        wr(CTRL_ADDR, 32'h0000_0000, r);
        s_axi_wstrb <= 4'hF;
        rd(CTRL_ADDR, d, r);
        chk("strobe", d, 32'h0000_FF00);
        wr(CTRL_ADDR, 32'h0, r);
        seq_inst.op(8'h13, 1'b1, 4'h0);
        ev(2'd1, vec(8'h10), FRAME_POST);
        seq_inst.op(8'h00, 1'b0, 4'h1);
        wr(STAT_ADDR, 32'h0100_0000, r);
        seq_inst.cond(16'h0092, 16'h0);
        ev(2'd2, 8'h02, 4'h0);
        rd(STAT_ADDR, d, r);
        chk("unordered", d[15:8], 8'h80);
        seq_inst.cond(16'h0000, 16'h0015);
        ev(2'd2, 8'h05, 4'h0);
        wr(CTRL_ADDR, 32'h0000_8000, r);
        repeat (2)
        begin
            seq_inst.cond(16'h0092, 16'h0);
            ev(2'd1, VEC_UNORD, FRAME_PRE);
        end
        seq_inst.save();
        seq_inst.cond(16'h0092, 16'h0);
        ev(2'd2, 8'h02, 4'h0);
        wr(CTRL_ADDR, 32'h0000_4000, r);
        seq_inst.op(8'h40, 1'b0, 4'h0);
        rd(RPT_ADDR, d, r);
        chk("report", d, {8'h00, vec(8'h40), 16'h0601});
        seq_inst.cond(16'h0081, 16'h0);
        ev(2'd1, vec(8'h40), FRAME_PRE);
        seq_inst.cond(16'h0081, 16'h0);
        ev(2'd2, 8'h01, 4'h0);
        end_sim();
    end
endmodule
